// File: logic/ncs_pkg.sv
// constants, register map, segment table defaults and state codes of the nvm config store control
// assumes one clock (the serial port clock) and a synchronous active-high reset
//
// Notes on behaviour
// - segment table holds start address and byte count per register range
// - segment table also holds apply-settings and end-of-data operation codes
// - reset table moves every register range, then issues apply-settings
// - pending bit reads 1 while a store or load moves data, else 0
// - status pin carries the pending bit while the status-pin select is set
// - error bit reads 1 when a loaded checksum mismatches, else 0
// - with boot-select pin low, soft-reload bit resets device and reloads nvm
// - soft-reload bit clears itself one clock after its register write
// - nvm writes are blocked while write-enable is 0, its reset value
// - writing 1 to store-trigger starts copying buffer bank into nvm
// - store-trigger bit returns to 0 once the store has finished
// - apply-settings pulses a copy of all buffer registers into active ones
package ncs_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register map
    localparam int unsigned NCS_AW = 12;
    localparam int unsigned NCS_DW = 8;
    localparam logic [11:0] NCS_ADDR_SEG_FIRST = 12'ha00;
    localparam logic [11:0] NCS_ADDR_SEG_LAST = 12'ha16;
    localparam logic [11:0] NCS_ADDR_PENDING = 12'hb00;
    localparam logic [11:0] NCS_ADDR_ERROR = 12'hb01;
    localparam logic [11:0] NCS_ADDR_RELOAD_UNLOCK = 12'hb02;
    localparam logic [11:0] NCS_ADDR_STORE = 12'hb03;

    // field positions
    localparam int unsigned NCS_PENDING_BIT = 0;
    localparam int unsigned NCS_ERROR_BIT = 0;
    localparam int unsigned NCS_UNLOCK_BIT = 0;
    localparam int unsigned NCS_RELOAD_BIT = 1;
    localparam int unsigned NCS_STORE_BIT = 0;

    // reset values of control bits
    localparam logic NCS_UNLOCK_RST = 1'b0;
    localparam logic NCS_RELOAD_RST = 1'b0;
    localparam logic NCS_STORE_RST = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // segment table: entry = {0,count-1[6:0]}, {4'h0,addr[11:8]}, addr[7:0]
    localparam int unsigned NCS_SEG_BYTES = 23;
    localparam int unsigned NCS_SEG_IW = 5;
    localparam logic [7:0] NCS_OP_APPLY = 8'h80;
    localparam logic [7:0] NCS_OP_END = 8'hff;
    localparam int unsigned NCS_OP_FLAG_BIT = 7;

    // seven 128-byte ranges cover 0x000..0x37f, then apply, then end
    localparam logic [7:0] NCS_SEG_RST [NCS_SEG_BYTES] = '{
        8'h7f, 8'h00, 8'h00,
        8'h7f, 8'h00, 8'h80,
        8'h7f, 8'h01, 8'h00,
        8'h7f, 8'h01, 8'h80,
        8'h7f, 8'h02, 8'h00,
        8'h7f, 8'h02, 8'h80,
        8'h7f, 8'h03, 8'h00,
        8'h80,
        8'hff
    };

    ////////////////////////////////////////////////////////////////////////////////
    // transfer engine states
    typedef enum logic [10:0] {
        S_IDLE    = 11'h001,
        S_OPCODE  = 11'h002,
        S_ADDR_HI = 11'h004,
        S_ADDR_LO = 11'h008,
        S_BANK_RD = 11'h010,
        S_BANK_WT = 11'h020,
        S_NVM     = 11'h040,
        S_BANK_WR = 11'h080,
        S_NEXT    = 11'h100,
        S_SUM     = 11'h200,
        S_UNUSED  = 11'h400
    } ncs_state_t;

endpackage

// File: logic/ncs_seg_if.sv
// read port between the transfer engine and the segment table
// assumes both ends sit on the same clock
`timescale 1ns/10ps
interface ncs_seg_if;
    import ncs_pkg::*;
    logic [NCS_SEG_IW-1:0] idx;
    logic [7:0] data;
    modport table_side (input idx, output data);
    modport engine_side (output idx, input data);
endinterface

// File: logic/ncs_seg_table.sv
// segment table storage with one write port and two read ports
// assumes writes come from the register port on the same clock
`timescale 1ns/10ps
module ncs_seg_table
    import ncs_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // register port
    input wire logic wr_i,
    input wire logic [NCS_SEG_IW-1:0] bus_idx_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] bus_data_o,
    // engine read port
    ncs_seg_if.table_side eng
);
    typedef struct packed {
        logic [NCS_SEG_BYTES-1:0][7:0] mem;
    } ncs_tab_t;

    ncs_tab_t r_reg;
    ncs_tab_t r_next;

    // out of range reads give end-of-data so the engine always stops
    function automatic logic [7:0] ncs_tab_rd(input ncs_tab_t t, input logic [NCS_SEG_IW-1:0] i);
        ncs_tab_rd = (i < NCS_SEG_IW'(NCS_SEG_BYTES)) ? t.mem[i] : NCS_OP_END;
    endfunction

    always_comb begin
        r_next = r_reg;
        if (wr_i && (bus_idx_i < NCS_SEG_IW'(NCS_SEG_BYTES))) begin
            r_next.mem[bus_idx_i] = wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            for (int i = 0; i < NCS_SEG_BYTES; i++) begin
                r_reg.mem[i] <= NCS_SEG_RST[i];
            end
        end else begin
            r_reg <= r_next;
        end
    end

    assign bus_data_o = ncs_tab_rd(r_reg, bus_idx_i);
    assign eng.data = ncs_tab_rd(r_reg, eng.idx);
endmodule // ncs_seg_table

// File: logic/ncs_pin_sync.sv
// two-flop synchroniser for asynchronous pin levels
// assumes the pin level is quasi-static
`timescale 1ns/10ps
module ncs_pin_sync #(
    parameter int unsigned W = 1
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ncs_sync_t;

    ncs_sync_t r_reg;
    ncs_sync_t r_next;

    always_comb begin
        r_next.s1 = pin_i;
        r_next.s2 = r_reg.s1;
    end

    // reset to all ones: the boot pin idles high, not asking for a reload
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            r_reg <= '1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign sync_o = r_reg.s2;
endmodule // ncs_pin_sync

// File: logic/ncs_nvm_ctrl.sv
// nvm config store control: register decode and transfer engine between
// the buffer register bank and the on-package nonvolatile memory
// assumes the register port, buffer bank and nvm share clk_i (serial port clock)
`timescale 1ns/10ps
module ncs_nvm_ctrl
    import ncs_pkg::*;
#(
    parameter int unsigned NVM_AW = 11
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // register port from the serial control port front end
    input wire logic [NCS_AW-1:0] reg_addr_i,
    input wire logic [NCS_DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [NCS_DW-1:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // pins and neighbours
    input wire logic boot_sel_n_i,
    input wire logic status_sel_i,
    output logic status_o,
    output logic soft_reset_o,
    output logic apply_o,
    // buffer register bank
    output logic [NCS_AW-1:0] bank_addr_o,
    output logic [NCS_DW-1:0] bank_wdata_o,
    output logic bank_wr_o,
    output logic bank_rd_o,
    input wire logic [NCS_DW-1:0] bank_rdata_i,
    // nonvolatile memory
    output logic [NVM_AW-1:0] nvm_addr_o,
    output logic [NCS_DW-1:0] nvm_wdata_o,
    output logic nvm_req_o,
    output logic nvm_we_o,
    input wire logic nvm_ack_i,
    input wire logic [NCS_DW-1:0] nvm_rdata_i
);

    ////////////////////////////////////////////////////////////////////////////////
    // elaboration check: default table needs 897 nvm bytes incl. checksum
    if (NVM_AW < 10 || NVM_AW > 16) begin : g_bad_nvm_aw
        $error("NVM_AW must lie between 10 and 16");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        ncs_state_t state;
        logic store_dir;
        logic [NCS_SEG_IW-1:0] idx;
        logic [6:0] count;
        logic [NCS_AW-1:0] addr;
        logic [NCS_DW-1:0] data;
        logic [NCS_DW-1:0] sum;
        logic [NVM_AW-1:0] ptr;
        logic pending;
        logic err;
        logic unlock;
        logic reload;
        logic store_trig;
        logic soft_rst;
        logic apply;
        logic status;
        logic bank_rd;
        logic bank_wr;
        logic nvm_req;
        logic nvm_we;
        logic [NCS_DW-1:0] rdata;
        logic rvalid;
    } ncs_ctrl_t;

    ncs_ctrl_t r_reg;
    ncs_ctrl_t r_next;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic ncs_in_seg(input logic [NCS_AW-1:0] a);
        ncs_in_seg = (a >= NCS_ADDR_SEG_FIRST) && (a <= NCS_ADDR_SEG_LAST);
    endfunction

    logic [NCS_SEG_IW-1:0] bus_idx;
    logic [NCS_DW-1:0] seg_bus_data;
    logic seg_wr;
    logic boot_sync;
    logic boot_low;
    logic busy;
    logic start_store;
    logic start_load;
    logic [NCS_AW-1:0] seg_off;

    ncs_seg_if seg ();

    assign seg_off = reg_addr_i - NCS_ADDR_SEG_FIRST;
    assign bus_idx = seg_off[NCS_SEG_IW-1:0];
    // table is frozen while the engine walks it
    assign busy = r_reg.state != S_IDLE;
    assign seg_wr = reg_wr_i && ncs_in_seg(reg_addr_i) && !busy;
    assign boot_low = !boot_sync;
    assign seg.idx = r_reg.idx;

    ////////////////////////////////////////////////////////////////////////////////
    // submodules
    ncs_seg_table u_table (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .wr_i(seg_wr),
        .bus_idx_i(bus_idx),
        .wdata_i(reg_wdata_i),
        .bus_data_o(seg_bus_data),
        .eng(seg)
    );

    ncs_pin_sync #(
        .W(1)
    ) u_boot_sync (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .pin_i(boot_sel_n_i),
        .sync_o(boot_sync)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        r_next = r_reg;
        r_next.soft_rst = 1'b0;
        r_next.apply = 1'b0;
        r_next.bank_rd = 1'b0;
        r_next.bank_wr = 1'b0;
        r_next.rvalid = 1'b0;
        r_next.reload = 1'b0;
        start_store = 1'b0;
        start_load = 1'b0;

        // register writes
        if (reg_wr_i && reg_addr_i == NCS_ADDR_RELOAD_UNLOCK) begin
            r_next.unlock = reg_wdata_i[NCS_UNLOCK_BIT];
            r_next.reload = reg_wdata_i[NCS_RELOAD_BIT];
        end
        // store refused while locked or busy
        if (reg_wr_i && reg_addr_i == NCS_ADDR_STORE && reg_wdata_i[NCS_STORE_BIT]
            && r_reg.unlock && !busy) begin
            start_store = 1'b1;
        end
        // reload acts in the cycle the bit reads 1, only with the boot pin low
        if (r_reg.reload && boot_low && !busy && !start_store) begin
            start_load = 1'b1;
            r_next.soft_rst = 1'b1;
        end

        if (start_store || start_load) begin
            r_next.state = S_OPCODE;
            r_next.store_dir = start_store;
            r_next.store_trig = start_store;
            r_next.pending = 1'b1;
            r_next.err = 1'b0;
            r_next.idx = '0;
            r_next.ptr = '0;
            r_next.sum = '0;
        end

        // transfer engine
        unique case (r_reg.state)
            S_IDLE: begin
            end
            S_OPCODE: begin
                r_next.idx = r_reg.idx + NCS_SEG_IW'(1);
                if (seg.data == NCS_OP_END) begin
                    r_next.state = S_SUM;
                    r_next.data = r_reg.sum;
                    r_next.idx = r_reg.idx;
                end else if (seg.data == NCS_OP_APPLY) begin
                    r_next.apply = 1'b1;
                end else if (!seg.data[NCS_OP_FLAG_BIT]) begin
                    r_next.count = seg.data[6:0];
                    r_next.state = S_ADDR_HI;
                end
            end
            S_ADDR_HI: begin
                r_next.addr[11:8] = seg.data[3:0];
                r_next.idx = r_reg.idx + NCS_SEG_IW'(1);
                r_next.state = S_ADDR_LO;
            end
            S_ADDR_LO: begin
                r_next.addr[7:0] = seg.data;
                r_next.idx = r_reg.idx + NCS_SEG_IW'(1);
                r_next.state = r_reg.store_dir ? S_BANK_RD : S_NVM;
            end
            S_BANK_RD: begin
                r_next.bank_rd = 1'b1;
                r_next.state = S_BANK_WT;
            end
            S_BANK_WT: begin
                // bank answers one cycle after the read strobe
                if (!r_reg.bank_rd) begin
                    r_next.data = bank_rdata_i;
                    r_next.state = S_NVM;
                end
            end
            S_NVM: begin
                if (nvm_ack_i) begin
                    r_next.ptr = r_reg.ptr + NVM_AW'(1);
                    if (r_reg.store_dir) begin
                        r_next.sum = r_reg.sum + r_reg.data;
                        r_next.state = S_NEXT;
                    end else begin
                        r_next.data = nvm_rdata_i;
                        r_next.sum = r_reg.sum + nvm_rdata_i;
                        r_next.state = S_BANK_WR;
                    end
                end
            end
            S_BANK_WR: begin
                r_next.bank_wr = 1'b1;
                r_next.state = S_NEXT;
            end
            S_NEXT: begin
                if (r_reg.count == 7'h00) begin
                    r_next.state = S_OPCODE;
                end else begin
                    r_next.count = r_reg.count - 7'h01;
                    r_next.addr = r_reg.addr + NCS_AW'(1);
                    r_next.state = r_reg.store_dir ? S_BANK_RD : S_NVM;
                end
            end
            S_SUM: begin
                // checksum byte follows the data in nvm
                if (nvm_ack_i) begin
                    if (!r_reg.store_dir) begin
                        r_next.err = nvm_rdata_i != r_reg.sum;
                    end
                    r_next.state = S_IDLE;
                    r_next.pending = 1'b0;
                    r_next.store_trig = 1'b0;
                end
            end
            default: begin
                r_next.state = S_IDLE;
                r_next.pending = 1'b0;
                r_next.store_trig = 1'b0;
            end
        endcase

        // nvm handshake: request holds until acknowledged
        r_next.nvm_req = (r_next.state == S_NVM || r_next.state == S_SUM)
            && !((r_reg.state == r_next.state) && nvm_ack_i);
        r_next.nvm_we = r_next.store_dir && r_reg.unlock;

        r_next.status = status_sel_i && r_next.pending;

        // register reads, answered one cycle later
        if (reg_rd_i) begin
            r_next.rvalid = 1'b1;
            r_next.rdata = '0;
            if (ncs_in_seg(reg_addr_i)) begin
                r_next.rdata = seg_bus_data;
            end else if (reg_addr_i == NCS_ADDR_PENDING) begin
                r_next.rdata[NCS_PENDING_BIT] = r_reg.pending;
            end else if (reg_addr_i == NCS_ADDR_ERROR) begin
                r_next.rdata[NCS_ERROR_BIT] = r_reg.err;
            end else if (reg_addr_i == NCS_ADDR_RELOAD_UNLOCK) begin
                r_next.rdata[NCS_UNLOCK_BIT] = r_reg.unlock;
                r_next.rdata[NCS_RELOAD_BIT] = r_reg.reload;
            end else if (reg_addr_i == NCS_ADDR_STORE) begin
                r_next.rdata[NCS_STORE_BIT] = r_reg.store_trig;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            r_reg <= '0;
            r_reg.state <= S_IDLE;
            r_reg.unlock <= NCS_UNLOCK_RST;
            r_reg.reload <= NCS_RELOAD_RST;
            r_reg.store_trig <= NCS_STORE_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign reg_rdata_o = r_reg.rdata;
    assign reg_rvalid_o = r_reg.rvalid;
    assign status_o = r_reg.status;
    assign soft_reset_o = r_reg.soft_rst;
    assign apply_o = r_reg.apply;
    assign bank_addr_o = r_reg.addr;
    assign bank_wdata_o = r_reg.data;
    assign bank_wr_o = r_reg.bank_wr;
    assign bank_rd_o = r_reg.bank_rd;
    assign nvm_addr_o = r_reg.ptr;
    assign nvm_wdata_o = r_reg.data;
    assign nvm_req_o = r_reg.nvm_req;
    assign nvm_we_o = r_reg.nvm_we;

endmodule // ncs_nvm_ctrl

// File: verification/ncs_nvm_ctrl_properties.sv
// port checker of the nvm config store control
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
module ncs_nvm_ctrl_properties
    import ncs_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // register port
    input wire logic [NCS_AW-1:0] reg_addr_i,
    input wire logic [NCS_DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic reg_rvalid_o,
    // pins and memories
    input wire logic status_sel_i,
    input wire logic status_o,
    input wire logic soft_reset_o,
    input wire logic apply_o,
    input wire logic bank_rd_o,
    input wire logic nvm_req_o,
    input wire logic nvm_we_o,
    input wire logic nvm_ack_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    ////////////////////////////////////////////////////////////////////////////////
    // unlock shadow
    logic unlock_reg;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            unlock_reg <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == NCS_ADDR_RELOAD_UNLOCK) begin
            unlock_reg <= reg_wdata_i[NCS_UNLOCK_BIT];
        end
    end

    sequence s_reload_wr;
        reg_wr_i && reg_addr_i == NCS_ADDR_RELOAD_UNLOCK && reg_wdata_i[NCS_RELOAD_BIT];
    endsequence
    sequence s_bank_fetch;
        bank_rd_o;
    endsequence
    sequence s_nvm_store;
        nvm_req_o && nvm_we_o;
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    chk_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read strobe not answered");
    chk_answer_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
        else $error("read answer without strobe");
    chk_status_gate: assert property (status_o |-> $past(status_sel_i))
        else $error("status pin high while deselected");
    chk_status_on: assert property (status_sel_i && nvm_req_o && !nvm_ack_i |=> status_o)
        else $error("status pin low");
    chk_store_unlock: assert property (s_nvm_store |-> unlock_reg || $past(unlock_reg))
        else $error("nvm write while locked");
    chk_req_hold: assert property (nvm_req_o && !nvm_ack_i |=> nvm_req_o)
        else $error("nvm request dropped before ack");
    chk_fetch_store: assert property (s_bank_fetch |-> ##[1:20] s_nvm_store)
        else $error("fetched byte not stored");
    chk_reload_cause: assert property (soft_reset_o |-> $past(reg_wr_i
        && reg_addr_i == NCS_ADDR_RELOAD_UNLOCK && reg_wdata_i[NCS_RELOAD_BIT], 2))
        else $error("soft reset without reload write");
    chk_reload_pulse: assert property (soft_reset_o |=> !soft_reset_o)
        else $error("soft reset longer than one cycle");
    chk_apply_pulse: assert property (apply_o |=> !apply_o)
        else $error("apply longer than one cycle");
    cov_reload: cover property (s_reload_wr ##2 soft_reset_o);
endmodule // ncs_nvm_ctrl_properties

bind ncs_nvm_ctrl ncs_nvm_ctrl_properties u_chk (.clk_i(clk_i), .srst_i(srst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rvalid_o(reg_rvalid_o), .status_sel_i(status_sel_i),
    .status_o(status_o), .soft_reset_o(soft_reset_o), .apply_o(apply_o),
    .bank_rd_o(bank_rd_o), .nvm_req_o(nvm_req_o), .nvm_we_o(nvm_we_o), .nvm_ack_i(nvm_ack_i));

// File: verification/ncs_far_model.sv
// model of the buffer bank and the nonvolatile memory
// assumes the controller clock; slow_i stretches nvm acks
`timescale 1ns/10ps
module ncs_far_model
    import ncs_pkg::*;
#(
    parameter int unsigned NVM_AW = 11
) (
    // clock and pace
    input wire logic clk_i,
    input wire logic slow_i,
    // nvm side
    input wire logic [NVM_AW-1:0] nvm_addr_i,
    input wire logic [7:0] nvm_wdata_i,
    input wire logic nvm_req_i,
    input wire logic nvm_we_i,
    output logic nvm_ack_o,
    output logic [7:0] nvm_rdata_o,
    // bank side
    input wire logic [NCS_AW-1:0] bank_addr_i,
    input wire logic [7:0] bank_wdata_i,
    input wire logic bank_wr_i,
    input wire logic bank_rd_i,
    output logic [7:0] bank_rdata_o
);
    logic [7:0] nvm_mem [2**NVM_AW];
    logic [7:0] bank_mem [4096];
    int wait_cnt = 0;
    initial begin
        nvm_ack_o = 1'b0;
        nvm_rdata_o = 8'h5a;
        bank_rdata_o = 8'ha5;
    end
    // idle data lines toggle so stale values never pass
    always @(posedge clk_i) begin
        bank_rdata_o <= bank_rd_i ? bank_mem[bank_addr_i] : ~bank_rdata_o;
        if (bank_wr_i) begin
            bank_mem[bank_addr_i] <= bank_wdata_i;
        end
        if (nvm_ack_o || !nvm_req_i) begin
            nvm_ack_o <= 1'b0;
            nvm_rdata_o <= ~nvm_rdata_o;
        end else if (wait_cnt < (slow_i ? 5 : 0)) begin
            wait_cnt++;
            nvm_rdata_o <= ~nvm_rdata_o;
        end else begin
            wait_cnt = 0;
            nvm_ack_o <= 1'b1;
            if (nvm_we_i) begin
                nvm_mem[nvm_addr_i] <= nvm_wdata_i;
            end else begin
                nvm_rdata_o <= nvm_mem[nvm_addr_i];
            end
        end
    end
endmodule // ncs_far_model

// File: verification/test_ncs_nvm_ctrl.sv
// self-checking bench of the nvm config store control
// assumes the far model stands in for nvm and buffer bank
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_ncs_nvm_ctrl;
    import ncs_pkg::*;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [11:0] reg_addr_i = 12'h000;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, boot_sel_n_i = 1'b1, status_sel_i = 1'b0, slow = 1'b0;
    logic [7:0] reg_rdata_o, bank_wdata_o, nvm_wdata_o, bank_rdata_i, nvm_rdata_i, rd, s;
    logic reg_rvalid_o, status_o, soft_reset_o, apply_o, bank_wr_o, bank_rd_o;
    logic nvm_req_o, nvm_we_o, nvm_ack_i;
    logic [11:0] bank_addr_o;
    logic [10:0] nvm_addr_o;
    logic [7:0] tbl [5] = '{8'h03, 8'h00, 8'h10, NCS_OP_APPLY, NCS_OP_END};
    int n_mismatch = 0, check_count = 0, seed = 2, n_apply = 0, n_soft = 0, k, c0;

    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) status_sel_i <= $random(seed);
    always @(negedge clk_i) begin
        n_apply += int'(apply_o === 1'b1);
        n_soft += int'(soft_reset_o === 1'b1);
    end

    ncs_nvm_ctrl #(.NVM_AW(11)) dut (.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .boot_sel_n_i(boot_sel_n_i),
        .status_sel_i(status_sel_i), .status_o(status_o), .soft_reset_o(soft_reset_o),
        .apply_o(apply_o), .bank_addr_o(bank_addr_o), .bank_wdata_o(bank_wdata_o),
        .bank_wr_o(bank_wr_o), .bank_rd_o(bank_rd_o), .bank_rdata_i(bank_rdata_i),
        .nvm_addr_o(nvm_addr_o), .nvm_wdata_o(nvm_wdata_o), .nvm_req_o(nvm_req_o),
        .nvm_we_o(nvm_we_o), .nvm_ack_i(nvm_ack_i), .nvm_rdata_i(nvm_rdata_i));
    ncs_far_model #(.NVM_AW(11)) u_far (.clk_i(clk_i), .slow_i(slow), .nvm_addr_i(nvm_addr_o),
        .nvm_wdata_i(nvm_wdata_o), .nvm_req_i(nvm_req_o), .nvm_we_i(nvm_we_o),
        .nvm_ack_o(nvm_ack_i), .nvm_rdata_o(nvm_rdata_i), .bank_addr_i(bank_addr_o),
        .bank_wdata_i(bank_wdata_o), .bank_wr_i(bank_wr_o), .bank_rd_i(bank_rd_o),
        .bank_rdata_o(bank_rdata_i));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic reg_rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // bounded poll of the pending bit
    task automatic wait_idle();
        logic [7:0] d;
        for (int i = 0; i < 20000; i++) begin
            reg_rd(NCS_ADDR_PENDING, d);
            if (d[NCS_PENDING_BIT] === 1'b0) return;
        end
        n_mismatch++;
        tally_and_finish();
    endtask
    // expected nvm image: bank bytes in order, then their 8-bit sum
    function automatic logic [7:0] sum_bank(input int base, input int n);
        logic [7:0] t = 8'h00;
        for (int i = 0; i < n; i++) t += u_far.bank_mem[base + i];
        return t;
    endfunction
    task automatic check_image(input int base, input int n);
        int bad = 0;
        for (int i = 0; i < n; i++) bad += int'(u_far.nvm_mem[i] !== u_far.bank_mem[base + i]);
        `CHK(bad, 0)
        `CHK(u_far.nvm_mem[n], sum_bank(base, n))
    endtask
    task automatic reload(input int exp_soft);
        c0 = n_soft;
        reg_wr(NCS_ADDR_RELOAD_UNLOCK, 8'h02);
        repeat (4) @(posedge clk_i);
        wait_idle();
        reg_rd(NCS_ADDR_RELOAD_UNLOCK, rd);
        `CHK(rd[NCS_RELOAD_BIT], 1'b0)
        `CHK(n_soft - c0, exp_soft)
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        for (k = 0; k < 4096; k++) u_far.bank_mem[k] = $random(seed);
        repeat (10) @(posedge clk_i);
        srst_i <= 1'b0;
        reg_rd(NCS_ADDR_PENDING, rd);
        `CHK(rd, 8'h00)
        reg_rd(NCS_ADDR_ERROR, rd);
        `CHK(rd, 8'h00)
        reg_rd(NCS_ADDR_RELOAD_UNLOCK, rd);
        `CHK(rd, 8'h00)
        reg_rd(NCS_ADDR_STORE, rd);
        `CHK(rd, 8'h00)
        reg_rd(12'h123, rd);
        `CHK(rd, 8'h00)
        for (k = 0; k < NCS_SEG_BYTES; k++) begin
            reg_rd(NCS_ADDR_SEG_FIRST + 12'(k), rd);
            `CHK(rd, NCS_SEG_RST[k])
        end
        $display("test reset_values done");
        // locked store must not start
        reg_wr(NCS_ADDR_STORE, 8'h01);
        reg_rd(NCS_ADDR_PENDING, rd);
        `CHK(rd[NCS_PENDING_BIT], 1'b0)
        $display("test locked_store done");
        // default table store against a slow nvm
        slow <= 1'b1;
        reg_wr(NCS_ADDR_RELOAD_UNLOCK, 8'h01);
        c0 = n_apply;
        reg_wr(NCS_ADDR_STORE, 8'h01);
        reg_rd(NCS_ADDR_STORE, rd);
        `CHK(rd[NCS_STORE_BIT], 1'b1)
        reg_rd(NCS_ADDR_PENDING, rd);
        `CHK(rd[NCS_PENDING_BIT], 1'b1)
        wait_idle();
        reg_rd(NCS_ADDR_STORE, rd);
        `CHK(rd[NCS_STORE_BIT], 1'b0)
        `CHK(n_apply - c0, 1)
        check_image(0, 896);
        $display("test default_store done");
        // reload restores a corrupted bank byte
        slow <= 1'b0;
        boot_sel_n_i <= 1'b0;
        u_far.bank_mem[5] = ~u_far.bank_mem[5];
        repeat (4) @(posedge clk_i);
        reload(1);
        `CHK(u_far.bank_mem[5], u_far.nvm_mem[5])
        reg_rd(NCS_ADDR_ERROR, rd);
        `CHK(rd[NCS_ERROR_BIT], 1'b0)
        // broken checksum gives an error
        u_far.nvm_mem[896] = ~u_far.nvm_mem[896];
        reload(1);
        reg_rd(NCS_ADDR_ERROR, rd);
        `CHK(rd[NCS_ERROR_BIT], 1'b1)
        // boot pin high blocks the reload
        boot_sel_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        reload(0);
        $display("test reload done");
        // short table: one range, apply, end
        for (k = 0; k < 5; k++) reg_wr(NCS_ADDR_SEG_FIRST + 12'(k), tbl[k]);
        reg_rd(NCS_ADDR_SEG_FIRST + 12'h003, rd);
        `CHK(rd, NCS_OP_APPLY)
        s = u_far.nvm_mem[5];
        reg_wr(NCS_ADDR_RELOAD_UNLOCK, 8'h01);
        reg_wr(NCS_ADDR_STORE, 8'h01);
        wait_idle();
        check_image(16, 4);
        `CHK(u_far.nvm_mem[5], s)
        $display("test short_table done");
        tally_and_finish();
    end
endmodule // test_ncs_nvm_ctrl
